// File: digital_core_sample_rate_control_tb_top.sv
`default_nettype none
module digital_core_sample_rate_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dsrc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
  logic [3:0] pstrb = 4'hf, loop_rate, pcyc;
  logic [RSC_GROUPS-1:0] src_act = '0, grp_async;
  // Slot rates in kHz: 48, 16, 96, 44, 192
  logic [8*RSC_SLOTS-1:0] khz = {8'hc0, 8'h2c, 8'h60, 8'h10, 8'h30};
  logic [4*RSC_GROUPS-1:0] grp_rate;
  logic [RSC_SLOTS-1:0] used;
  logic pready, perr, erv;
  int err_count = 0, num_checks = 0, cyc = 0;
  // Free running 100 MHz clock
  always #5 clk = ~clk;
  // Short settle count keeps the guard test quick
  dsrc_top #(.SETTLE_CYC(8)) DUT (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
    .pready_o(pready), .pslverr_o(perr), .prdata_o(prdata), .src_active_i(src_act),
    .slot_khz_i(khz), .grp_rate_o(grp_rate), .grp_async_o(grp_async), .slot_used_o(used),
    .loopback_rate_o(loop_rate), .pulse_cycle_rate_o(pcyc));
  task close_out;
    if (err_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  // One APB transfer; request held until pready seen high
  task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    erv = perr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task wr(input logic [31:0] a, input logic [3:0] c);
    xfer(1'b1, a, {17'h0, c, 11'h0});
  endtask
  task rchk(input logic [31:0] a, input logic [3:0] c, input string m);
    xfer(1'b0, a, '0);
    chk(rd, {17'h0, c, 11'h0}, m);
  endtask
  function automatic logic [31:0] app(input int g);
    return 32'(grp_rate[4*g +: 4]);
  endfunction
  task t_reset;
    chk(32'(grp_rate === '0 && grp_async === '0), 32'h1, "codes after reset");
    chk(32'(used), 32'h1, "slots after reset");
    rchk(RSC_OFFS[G_TONE], 4'h0, "tone after reset");
  endtask
  task automatic t_codes;
    logic [3:0] cs [5] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9};
    for (int i = 0; i < 5; i++) begin
      wr(RSC_OFFS[G_TONE], cs[i]);
      chk(app(G_TONE), 32'(cs[i]), "tone applied");
      chk(32'(grp_async[G_TONE]), 32'(cs[i][3]), "tone domain");
      chk(32'(used), 32'h1 | (32'h1 << i), "slot use");
      rchk(RSC_OFFS[G_TONE], cs[i], "tone readback");
    end
  endtask
  task t_reserved;
    wr(RSC_OFFS[G_HAP], 4'h9);
    wr(RSC_OFFS[G_HAP], 4'h5);
    chk(app(G_HAP), 32'h9, "reserved applied");
    rchk(RSC_OFFS[G_HAP], 4'h5, "reserved stored");
    @(posedge clk);
    pstrb <= 4'hd;
    wr(RSC_OFFS[G_HAP], 4'h1);
    rchk(RSC_OFFS[G_HAP], 4'h5, "lane off write");
    @(posedge clk);
    pstrb <= 4'hf;
  endtask
  task t_inout;
    wr(RSC_OFFS[G_OUT], 4'h2);
    chk(32'(loop_rate), 32'h2, "loopback rate");
    wr(RSC_OFFS[G_OUT], 4'h8);
    chk(app(G_OUT), 32'h2, "output async");
    wr(RSC_OFFS[G_IN], 4'h9);
    chk(app(G_IN), 32'h0, "input async");
    wr(RSC_OFFS[G_PWM], 4'h1);
    chk(32'(pcyc), 32'h1, "pulse cycle rate");
  endtask
  // Ports, consumer tx, link, effects and cores, mixed domains
  task t_groups;
    for (int g = G_AIF0; g < RSC_GROUPS; g++) begin
      wr(RSC_OFFS[g], (g % 2) ? 4'h8 : 4'h2);
    end
    for (int g = G_AIF0; g < RSC_GROUPS; g++) begin
      chk(app(g), (g % 2) ? 32'h8 : 32'h2, "group applied");
      rchk(RSC_OFFS[g], (g % 2) ? 4'h8 : 4'h2, "group readback");
    end
  endtask
  task t_unmapped;
    xfer(1'b0, 32'h0001_0020, '0);
    chk(32'(erv), 32'h1, "unmapped error");
    chk(rd, 32'h0, "unmapped data");
    wr(32'h0001_0020, 4'h1);
    rchk(RSC_OFFS[G_TONE], 4'h9, "aliased write");
  endtask
  task t_guard;
    xfer(1'b1, OFF_GUARD_LO, '1);
    @(posedge clk);
    src_act[G_HAP] <= 1'b1;
    wr(RSC_OFFS[G_HAP], 4'h1);
    chk(app(G_HAP), 32'h1, "guarded write applied");
    xfer(1'b0, OFF_GUARD_LO, '0);
    chk(rd, 32'h4, "guard while active");
    xfer(1'b1, OFF_GUARD_LO, '1);
    @(posedge clk);
    src_act[G_HAP] <= 1'b0;
    wr(RSC_OFFS[G_HAP], 4'h2);
    xfer(1'b0, OFF_GUARD_LO, '0);
    chk(rd, 32'h4, "guard while settling");
    xfer(1'b1, OFF_GUARD_LO, '1);
    repeat (12) @(posedge clk);
    wr(RSC_OFFS[G_HAP], 4'h0);
    xfer(1'b0, OFF_GUARD_LO, '0);
    chk(rd, 32'h0, "guard after settling");
  endtask
  // Slot 1 swept across both range edges
  task automatic t_range;
    logic [7:0] k [4] = '{8'h04, 8'hc1, 8'hc0, 8'h08};
    wr(RSC_OFFS[G_TONE], 4'h1);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      khz[15:8] <= k[i];
      repeat (2) @(posedge clk);
      xfer(1'b0, OFF_RANGE_LO, '0);
      chk(rd & 32'h1, (i < 2) ? 32'h1 : 32'h0, "range flag");
    end
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      close_out;
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset;
    t_codes;
    t_reserved;
    t_inout;
    t_groups;
    t_unmapped;
    t_guard;
    t_range;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    t_reset;
    close_out;
  end
endmodule
`default_nettype wire

// File: dsrc_cell.sv
`default_nettype none
module dsrc_cell #(
  parameter bit ALLOW_ASYNC = 1'b1,
  parameter int SETTLE = 12500
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic wr_i,
  input wire logic [3:0] code_i,
  input wire logic src_active_i,
  input wire logic viol_clr_i,
  output logic [3:0] stored_o,
  output logic [3:0] eff_o,
  output logic viol_o
);
  import dsrc_pkg::*;

  localparam int CW = $clog2(SETTLE + 1);

  // Stored code, applied code, settle countdown, guard flag
  typedef struct packed {
    logic [3:0] stored;
    logic [3:0] eff;
    logic [CW-1:0] settle;
    logic viol;
  } dsrc_cell_t;

  dsrc_cell_t st_ff;
  dsrc_cell_t nxt_st;
  logic code_ok;

  // Refuse settle counts below one cycle
  if (SETTLE < 1) begin : g_chk
    $error("SETTLE must be at least one cycle");
  end

  // Legal codes for this group
  always_comb begin
    unique case (code_i)
      RATE_SYNC1, RATE_SYNC2, RATE_SYNC3: code_ok = 1'b1;
      RATE_ASYNC1, RATE_ASYNC2: code_ok = ALLOW_ASYNC;
      default: code_ok = 1'b0;
    endcase
  end

  // Next state
  always_comb begin
    nxt_st = st_ff;
    // Restart settle window while any source is still routed
    if (src_active_i) begin
      nxt_st.settle = CW'(SETTLE);
    end else if (st_ff.settle != '0) begin
      nxt_st.settle = st_ff.settle - CW'(1);
    end
    if (viol_clr_i) begin
      nxt_st.viol = 1'b0;
    end
    if (wr_i) begin
      nxt_st.stored = code_i;
      // Reserved code keeps the group where it was
      if (code_ok) begin
        nxt_st.eff = code_i;
      end
      // Early write flagged; set beats a same-cycle clear
      if (src_active_i || st_ff.settle != '0) begin
        nxt_st.viol = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '{stored: RATE_RESET, eff: RATE_RESET, settle: '0, viol: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign stored_o = st_ff.stored;
  assign eff_o = st_ff.eff;
  assign viol_o = st_ff.viol;
endmodule
`default_nettype wire

// File: dsrc_pkg.sv
`default_nettype none
package dsrc_pkg;
  // Number of rate groups and the rate field position
  localparam int RSC_GROUPS = 35;
  localparam int RSC_FIELD_LSB = 11;
  localparam int RSC_FIELD_MSB = 14;
  localparam int RSC_SLOTS = 5;

  // Group indices
  localparam int G_TONE = 0;
  localparam int G_PWM = 1;
  localparam int G_HAP = 2;
  localparam int G_NOISE = 3;
  localparam int G_IN = 4;
  localparam int G_OUT = 5;
  localparam int G_AIF0 = 6;
  localparam int G_SPD = 10;
  localparam int G_LRX0 = 11;
  localparam int G_LTX0 = 19;
  localparam int G_FX = 27;
  localparam int G_DSP0 = 28;

  // Rate codes
  localparam logic [3:0] RATE_SYNC1 = 4'h0;
  localparam logic [3:0] RATE_SYNC2 = 4'h1;
  localparam logic [3:0] RATE_SYNC3 = 4'h2;
  localparam logic [3:0] RATE_ASYNC1 = 4'h8;
  localparam logic [3:0] RATE_ASYNC2 = 4'h9;
  localparam logic [3:0] RATE_RESET = 4'h0;

  // Register byte offsets, one per group
  localparam logic [31:0] RSC_OFFS [RSC_GROUPS] = '{
    32'h0000_0020, 32'h0000_0030, 32'h0000_0090, 32'h0000_00a0,
    32'h0000_0308, 32'h0000_0408,
    32'h0000_0500, 32'h0000_0540, 32'h0000_0580, 32'h0000_05a0,
    32'h0000_05c0,
    32'h0000_05e0, 32'h0000_05e4, 32'h0000_05e8, 32'h0000_05ec,
    32'h0000_05f0, 32'h0000_05f4, 32'h0000_05f8, 32'h0000_05fc,
    32'h0000_0600, 32'h0000_0604, 32'h0000_0608, 32'h0000_060c,
    32'h0000_0610, 32'h0000_0614, 32'h0000_0618, 32'h0000_061c,
    32'h0000_0e00,
    32'h0000_3000, 32'h0000_3004, 32'h0000_3008, 32'h0000_300c,
    32'h0000_3010, 32'h0000_3014, 32'h0000_3018};

  // Status registers and the start of the wide register decode
  localparam logic [31:0] OFF_GUARD_LO = 32'h0000_0700;
  localparam logic [31:0] OFF_GUARD_HI = 32'h0000_0704;
  localparam logic [31:0] OFF_RANGE_LO = 32'h0000_0708;
  localparam logic [31:0] OFF_RANGE_HI = 32'h0000_070c;
  localparam logic [31:0] OFF_WIDE_BASE = 32'h0000_3000;

  // Valid rate range in kHz
  localparam logic [7:0] RATE_MIN_KHZ = 8'd8;
  localparam logic [7:0] RATE_MAX_KHZ = 8'd192;

  // Settling time after sources are cleared
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETTLE_NS = 125000;
  localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// File: dsrc_top.sv
// Local design decision: the APB register port.
`default_nettype none
module dsrc_top #(
  parameter int SETTLE_CYC = dsrc_pkg::SETTLE_CYCLES,
  parameter int NUM_GROUPS = dsrc_pkg::RSC_GROUPS
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic pready_o,
  output logic pslverr_o,
  output logic [31:0] prdata_o,
  // Mixer source selector nonzero, one bit per group
  input wire logic [dsrc_pkg::RSC_GROUPS-1:0] src_active_i,
  // Frequency of each of the five rate slots, 8 bits of kHz each
  input wire logic [8*dsrc_pkg::RSC_SLOTS-1:0] slot_khz_i,
  // Applied rate code per group, 4 bits each
  output logic [4*dsrc_pkg::RSC_GROUPS-1:0] grp_rate_o,
  // Group runs on the asynchronous clock
  output logic [dsrc_pkg::RSC_GROUPS-1:0] grp_async_o,
  // Rate slots in use by at least one group
  output logic [dsrc_pkg::RSC_SLOTS-1:0] slot_used_o,
  // Two groups needing a converter between them are flagged by the mixer
  output logic [3:0] loopback_rate_o,
  output logic [3:0] pulse_cycle_rate_o
);
  import dsrc_pkg::*;

  // Refuse a group count that does not match the offset map
  if (NUM_GROUPS != RSC_GROUPS) begin : g_chk_groups
    $error("NUM_GROUPS must match the register map");
  end
  // Refuse a settle window of zero
  if (SETTLE_CYC < 1) begin : g_chk_settle
    $error("SETTLE_CYC must be at least one cycle");
  end

  // Register map, one 32-bit word per group, field in bits 14:11
  //   0x020 tone generator
  //   0x030 pulse-width generator
  //   0x090 vibration generator
  //   0x0a0 comfort noise generator
  //   0x308 input paths, sync codes only
  //   0x408 output paths and echo loopback, sync codes only
  //   0x500 0x540 0x580 0x5a0 audio ports one to four
  //   0x5c0 consumer audio transmitter
  //   0x5e0 to 0x5fc link receive channels one to eight
  //   0x600 to 0x61c link transmit channels one to eight
  //   0xe00 effects: equaliser, filters and range control together
  //   0x3000 to 0x3018 processor cores one to seven
  //   0x700 guard flags of groups 0 to 31, write one to clear
  //   0x704 guard flags of groups 32 to 34, write one to clear
  //   0x708 range flags of groups 0 to 31, read only
  //   0x70c range flags of groups 32 to 34, read only
  //   Anything else answers with an error and reads zero
  //
  // Bus timing
  //   Zero wait states: ready is tied high
  //   Read data is captured in the setup cycle and stands
  //   until the next setup cycle, so a slow master still sees it
  //   A write lands at the edge that ends the access phase
  //   The rate field sits in byte lane 1; a write without that
  //   strobe leaves the selector untouched
  //
  // Guard against early rate changes
  //   Each group reloads a settle counter while its mixer
  //   sources are routed and counts down once they are cleared
  //   A rate write inside that window is still applied, since
  //   holding it back would hide the software fault; instead the
  //   group's guard flag is raised for software to inspect
  //   A set in the same cycle as a clear wins, so no event is lost
  //
  // Reserved codes
  //   Stored and read back so software sees what it wrote,
  //   but the group keeps running at the last legal rate
  //   Async codes on the input and output groups count as reserved
  //
  // Limitations
  //   The block only selects rates; converters, mixers and clock
  //   generators sit elsewhere and act on the outputs below
  //   The oversampled microphone cap on the input rate is left to software

  // Result of an address lookup
  typedef struct packed {
    logic hit;
    logic [5:0] idx;
  } dsrc_hit_t;

  // Bus-facing state of the top
  typedef struct packed {
    logic [31:0] rdata;
    logic err;
  } dsrc_state_t;

  dsrc_state_t st_ff; // Registered read answer
  dsrc_state_t nxt_st; // Its next value
  dsrc_hit_t hit; // Decoded rate register
  logic setup_ph; // APB setup phase
  logic access_ph; // APB access phase
  logic wr_acc; // Write taking effect this edge
  logic word_wr; // Byte lane 1 written by the strobes
  logic [3:0] stored [RSC_GROUPS]; // Codes as software wrote them
  logic [3:0] eff [RSC_GROUPS]; // Codes actually in force
  logic [RSC_GROUPS-1:0] viol; // Guard violation flags
  logic [RSC_GROUPS-1:0] range_bad; // Selected slot out of range
  logic [RSC_GROUPS-1:0] cell_wr; // Write pulse per group
  logic [RSC_GROUPS-1:0] viol_clr; // Clear pulse per group
  logic [63:0] clr_mask; // W1C mask across both status words
  logic [31:0] rd_mux; // Read data before the flop
  logic rd_err; // Unmapped address

  // Map an address onto a rate group
  function automatic dsrc_hit_t find_reg(input logic [31:0] addr);
    dsrc_hit_t r;
    r.hit = 1'b0;
    r.idx = '0;
    // Narrow registers decode 16 bits; upper bits set there is an alias, refused
    if (addr[31:16] != 16'h0000 && addr[15:0] < OFF_WIDE_BASE[15:0]) begin
      return r;
    end
    for (int g = 0; g < RSC_GROUPS; g++) begin
      if (addr == RSC_OFFS[g]) begin
        r.hit = 1'b1;
        r.idx = 6'(g);
      end
    end
    return r;
  endfunction

  // Slot number for a code; five means none
  function automatic logic [2:0] code_slot(input logic [3:0] code);
    logic [2:0] s;
    s = 3'd5;
    unique case (code)
      RATE_SYNC1: s = 3'd0;
      RATE_SYNC2: s = 3'd1;
      RATE_SYNC3: s = 3'd2;
      RATE_ASYNC1: s = 3'd3;
      RATE_ASYNC2: s = 3'd4;
      default: s = 3'd5;
    endcase
    return s;
  endfunction

  // True when the code picks the asynchronous clock
  function automatic logic is_async(input logic [3:0] code);
    return code[3];
  endfunction

  // Phase decode
  always_comb begin
    setup_ph = psel_i && !penable_i;
    access_ph = psel_i && penable_i;
    wr_acc = access_ph && pwrite_i;
    word_wr = pstrb_i[1];
    hit = find_reg(paddr_i);
  end

  // One cell per group; input and output paths refuse async codes
  for (genvar g = 0; g < RSC_GROUPS; g++) begin : g_cell
    localparam bit SYNC_ONLY = (g == G_IN) || (g == G_OUT);
    dsrc_cell #(
      .ALLOW_ASYNC(!SYNC_ONLY),
      .SETTLE(SETTLE_CYC)
    ) u_cell (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .wr_i(cell_wr[g]),
      .code_i(pwdata_i[RSC_FIELD_MSB:RSC_FIELD_LSB]),
      .src_active_i(src_active_i[g]),
      .viol_clr_i(viol_clr[g]),
      .stored_o(stored[g]),
      .eff_o(eff[g]),
      .viol_o(viol[g])
    );
  end

  // Write pulses and status clears
  always_comb begin
    cell_wr = '0;
    clr_mask = '0;
    // Field lives in byte lane 1, so only that strobe moves it
    if (wr_acc && hit.hit && word_wr) begin
      cell_wr[hit.idx] = 1'b1;
    end
    // Guard flags clear by writing one, byte lanes honoured
    if (wr_acc && paddr_i == OFF_GUARD_LO) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb_i[b]) begin
          clr_mask[8*b +: 8] = pwdata_i[8*b +: 8];
        end
      end
    end
    if (wr_acc && paddr_i == OFF_GUARD_HI) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb_i[b]) begin
          clr_mask[32 + 8*b +: 8] = pwdata_i[8*b +: 8];
        end
      end
    end
    viol_clr = clr_mask[RSC_GROUPS-1:0];
  end

  // Range check of each group against the five slot frequencies
  always_comb begin
    logic [2:0] s;
    logic [7:0] khz;
    s = '0;
    khz = '0;
    range_bad = '0;
    for (int g = 0; g < RSC_GROUPS; g++) begin
      s = code_slot(eff[g]);
      khz = (s < 3'd5) ? slot_khz_i[8*s +: 8] : 8'h00;
      range_bad[g] = (khz < RATE_MIN_KHZ) || (khz > RATE_MAX_KHZ);
    end
  end

  // Per-group outputs and slot usage
  always_comb begin
    logic [2:0] s;
    s = '0;
    slot_used_o = '0;
    for (int g = 0; g < RSC_GROUPS; g++) begin
      // Mixer compares these codes to decide where a converter is needed
      grp_rate_o[4*g +: 4] = eff[g];
      // A single code bit names the domain, so no path can sit in both
      // Domain flag tells which side a cross-domain converter bridges
      grp_async_o[g] = is_async(eff[g]);
      s = code_slot(eff[g]);
      // Encoding allows only five distinct slots in total
      if (s < 3'd5) begin
        // Slots in use show which same-domain converter pairs are needed
        slot_used_o[s] = 1'b1;
      end
    end
    // Loopback and output mixers follow the output group
    loopback_rate_o = eff[G_OUT];
    // Pulse generator cycle time follows its own group
    pulse_cycle_rate_o = eff[G_PWM];
  end

  // Read multiplexer
  always_comb begin
    rd_mux = '0;
    rd_err = 1'b0;
    if (hit.hit) begin
      // Read back what was written, even a reserved code
      rd_mux[RSC_FIELD_MSB:RSC_FIELD_LSB] = stored[hit.idx];
    end else if (paddr_i == OFF_GUARD_LO) begin
      rd_mux = viol[31:0];
    end else if (paddr_i == OFF_GUARD_HI) begin
      rd_mux[RSC_GROUPS-33:0] = viol[RSC_GROUPS-1:32];
    end else if (paddr_i == OFF_RANGE_LO) begin
      rd_mux = range_bad[31:0];
    end else if (paddr_i == OFF_RANGE_HI) begin
      rd_mux[RSC_GROUPS-33:0] = range_bad[RSC_GROUPS-1:32];
    end else begin
      rd_err = 1'b1;
    end
  end

  // Next bus state: answer is captured in the setup cycle
  always_comb begin
    nxt_st = st_ff;
    if (setup_ph) begin
      nxt_st.rdata = pwrite_i ? 32'h0000_0000 : rd_mux;
      nxt_st.err = rd_err;
    end
  end

  // Bus state register
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '{rdata: 32'h0000_0000, err: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // No wait states; error only while the access phase lasts
  assign pready_o = 1'b1;
  assign pslverr_o = access_ph && st_ff.err;
  assign prdata_o = st_ff.rdata;
endmodule
`default_nettype wire

// File: dsrc_top_props.sv
`default_nettype none
module dsrc_top_props #(
  parameter int SETTLE_CYC = dsrc_pkg::SETTLE_CYCLES,
  parameter int NUM_GROUPS = dsrc_pkg::RSC_GROUPS
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic pslverr_o,
  input wire logic [4*dsrc_pkg::RSC_GROUPS-1:0] grp_rate_o,
  input wire logic [dsrc_pkg::RSC_GROUPS-1:0] grp_async_o,
  input wire logic [dsrc_pkg::RSC_SLOTS-1:0] slot_used_o,
  input wire logic [3:0] loopback_rate_o,
  input wire logic [3:0] pulse_cycle_rate_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import dsrc_pkg::*;
  logic [RSC_GROUPS-1:0] async_exp; // Domain bit per group
  logic [RSC_SLOTS-1:0] slot_exp; // Slots any group sits on
  logic all_legal; // No group currently has a reserved code applied
  logic [3:0] c;
  // Decode applied codes into domains and slots
  always_comb begin
    async_exp = '0;
    slot_exp = '0;
    all_legal = 1'b1;
    c = 4'h0;
    for (int g = 0; g < RSC_GROUPS; g++) begin
      c = grp_rate_o[4*g +: 4];
      async_exp[g] = c[3];
      case (c)
        4'h0: slot_exp[0] = 1'b1;
        4'h1: slot_exp[1] = 1'b1;
        4'h2: slot_exp[2] = 1'b1;
        4'h8: slot_exp[3] = 1'b1;
        4'h9: slot_exp[4] = 1'b1;
        default: all_legal = 1'b0;
      endcase
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  err_in_access_a: assert property (pslverr_o |-> psel_i && penable_i)
    else $error("error flag outside access");
  async_domain_a: assert property (grp_async_o == async_exp)
    else $error("domain flag wrong");
  slot_usage_a: assert property (slot_used_o == slot_exp)
    else $error("slot usage wrong");
  legal_applied_a: assert property (all_legal)
    else $error("reserved code applied");
  sync_in_out_a: assert property (grp_rate_o[19:16] <= 4'h2 && grp_rate_o[23:20] <= 4'h2)
    else $error("converter path left sync domain");
  loopback_follow_a: assert property (loopback_rate_o == grp_rate_o[23:20])
    else $error("loopback rate differs");
  pulse_follow_a: assert property (pulse_cycle_rate_o == grp_rate_o[7:4])
    else $error("pulse cycle rate differs");
  tone_only_a: assert property (
    psel_i && penable_i && pwrite_i && paddr_i == RSC_OFFS[G_TONE]
    |=> $stable(grp_rate_o[139:4])) else $error("tone write moved other group");
endmodule
bind dsrc_top dsrc_top_props #(.SETTLE_CYC(SETTLE_CYC), .NUM_GROUPS(NUM_GROUPS)) u_props (
  .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pslverr_o(pslverr_o), .grp_rate_o(grp_rate_o),
  .grp_async_o(grp_async_o), .slot_used_o(slot_used_o), .loopback_rate_o(loopback_rate_o),
  .pulse_cycle_rate_o(pulse_cycle_rate_o));
`default_nettype wire
